//--- core/ism_core.v
`timescale 1ns/1ps
`include "ism_regs.vh"
// Function
// - Master buffer write while bus busy sets write collision; software clears.
// - Slave buffer write while shifting previous byte sets write collision.
// - Byte received while buffer still full sets overflow; software clears.
// - Port enable in a slave or master mode with both directions input hands SDA/SCL to the port, else general-purpose I/O.
// - Slave: clock release bit low holds SCL low, high releases it.
// - Modes 1111/1110 select 10/7-bit slave with start/stop interrupts.
// - Modes 0111/0110 select 10/7-bit slave without start/stop interrupts.
// - Mode 1011 is firmware master, slave idle; other codes select nothing.
// - Mode 1000 is hardware master, bus clock = clk/(4*(reload+1)).
// - With general-call enable, all-zero address raises the interrupt in 7-bit slave modes.
// - Master transmit records slave acknowledge: 1 none, 0 received.
// - Acknowledge request drives acknowledge data bit, then self-clears.
// - Receive request clocks one byte in from the slave.
// - Start, repeated start, stop requests make conditions, then self-clear.
// - Slave stretch enable stretches receive too; clear stretches transmit only.
// - While busy, requests and buffer writes are ignored.
// - Enabled bus mode drives pins open-drain when directions are inputs.
// - Slave flags every address match; start/stop only in interrupt modes.
// - Full or overflow: no acknowledge, no buffer load, flag still set.
// - Slave shifts eight bits on SCL rise, compares bits 7:1 on 8th fall.
// - Match loads buffer, sets full, acknowledges, flags on 9th fall.
// - 10-bit first byte is 11110, A9, A8, write; then low byte.
// - Each 10-bit address byte holds SCL; all but a read-form repeated high byte set update flag.
// - Master uses low seven address bits as baud reload value.
// - Completed received byte moves to buffer and sets the interrupt flag.
module ism_core
(
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire [1:0] port_c_direction,
	input  wire       gpio_scl_out,
	input  wire       gpio_scl_oe,
	input  wire       gpio_sda_out,
	input  wire       gpio_sda_oe,
	input  wire       scl_in,
	output reg        scl_out,
	output reg        scl_oe,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	output reg        serial_irq_flag
);
	localparam [2:0] M_IDLE = 3'd0;
	localparam [2:0] M_STRT = 3'd1;
	localparam [2:0] M_RSTR = 3'd2;
	localparam [2:0] M_STOP = 3'd3;
	localparam [2:0] M_TX   = 3'd4;
	localparam [2:0] M_RX   = 3'd5;
	localparam [2:0] M_ACK  = 3'd6;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg       write_collision_flag_reg, ov_reg, en_reg, ckp_reg;
	reg [3:0] mode_reg;
	reg       general_call_enable_reg, ackst_reg, ack_data_bit_reg, ack_sequence_request_reg;
	reg       receive_request_reg, pen_reg, repeated_start_request_reg, sen_reg;
	reg [1:0] smpcke_reg;
	reg       da_reg, p_reg, s_reg, rw_reg, ua_reg, bf_reg;
	reg [7:0] buf_reg, sr_reg, adr_reg;
	reg       scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
	reg [2:0] mst_reg;
	reg [6:0] baud_reg;
	reg [1:0] ph_reg;
	reg [3:0] mbit_reg;
	reg       m_scl_lo, m_sda_lo;
	reg [3:0] scnt_reg;
	reg       s_act, s_adr, s_tx, s_ack, s_pend, hold_reg;
	reg [1:0] stage_reg;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire slv  = en_reg & (mode_reg == `ISM_MODE_S7 | mode_reg == `ISM_MODE_S10 |
		mode_reg == `ISM_MODE_S7I | mode_reg == `ISM_MODE_S10I);
	wire ten  = slv & mode_reg[0];
	wire ssi  = slv & mode_reg[3];
	wire hwm  = en_reg & (mode_reg == `ISM_MODE_HWM);
	wire fwm  = en_reg & (mode_reg == `ISM_MODE_FWM);
	wire busy = (mst_reg != M_IDLE) | rw_reg & hwm;
	wire wr_buf = reg_wr & (reg_addr == `ISM_OFF_BUF);
	wire tick = (baud_reg == 7'h00);
	// Edge detection reads only the second and third stages
	wire rise  = scl_s2 & ~scl_s3;
	wire fall  = ~scl_s2 & scl_s3;
	wire start = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
	wire stop  = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
	// Address compare: 7-bit on bits 7:1, 10-bit low byte on all eight
	wire a7  = (sr_reg[7:1] == adr_reg[7:1]);
	wire gc  = general_call_enable_reg & (sr_reg == 8'h00);
	wire hit = ten ? ((stage_reg == 2'd1) ? (sr_reg == adr_reg) :
		(a7 & sr_reg[7:3] == `ISM_TENBIT_HI)) : (a7 | gc);
	wire full = bf_reg | ov_reg;
	wire s_sda_lo = s_ack | (s_tx & s_act & (scnt_reg < 4'd8) & ~sr_reg[7]);
	wire hold_want = slv & s_act & (scnt_reg == 4'd0) & (~ckp_reg | ua_reg);
	wire pins_on = en_reg & (slv | hwm | fwm) & (&port_c_direction);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Third stage only feeds edge compare; metastability settles in the first two
	always @(posedge ref_clk)
	begin
		scl_s1 <= scl_in;
		scl_s2 <= scl_s1;
		scl_s3 <= scl_s2;
		sda_s1 <= sda_in;
		sda_s2 <= sda_s1;
		sda_s3 <= sda_s2;
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Open drain: output level is low whenever the port owns the pins, the enable pulls the wire
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			scl_out <= 1'b0;
			scl_oe  <= 1'b0;
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
			hold_reg <= 1'b0;
		end
		else
		begin
			// Stretch only once SCL is already low, never cut a high time short
			hold_reg <= hold_want & (~scl_s2 | hold_reg);
			scl_out <= pins_on ? 1'b0 : gpio_scl_out;
			sda_out <= pins_on ? 1'b0 : gpio_sda_out;
			scl_oe  <= pins_on ? (m_scl_lo | hold_reg) : gpio_scl_oe;
			sda_oe  <= pins_on ? (m_sda_lo | s_sda_lo) : gpio_sda_oe;
		end
	end

	// ----------------------------------------
	// Registers, master sequencer, slave engine
	// ----------------------------------------
	// Software writes come first so that hardware sets later in the block win
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			{write_collision_flag_reg, ov_reg, en_reg, ckp_reg, mode_reg} <= `ISM_RST_BYTE;
			{general_call_enable_reg, ackst_reg, ack_data_bit_reg, ack_sequence_request_reg} <= 4'h0;
			{receive_request_reg, pen_reg, repeated_start_request_reg, sen_reg} <= 4'h0;
			smpcke_reg <= 2'b00;
			{da_reg, p_reg, s_reg, rw_reg, ua_reg, bf_reg} <= 6'h00;
			buf_reg <= `ISM_RST_BYTE;
			sr_reg <= `ISM_RST_BYTE;
			adr_reg <= `ISM_RST_BYTE;
			reg_rdata <= 8'h00;
			serial_irq_flag <= 1'b0;
			mst_reg <= M_IDLE;
			baud_reg <= 7'h00;
			ph_reg <= 2'b00;
			mbit_reg <= 4'h0;
			m_scl_lo <= 1'b0;
			m_sda_lo <= 1'b0;
			scnt_reg <= 4'h0;
			{s_act, s_adr, s_tx, s_ack, s_pend} <= 5'h00;
			stage_reg <= 2'd0;
		end
		else
		begin
			// Bus read: data only in the cycle after the strobe
			reg_rdata <= 8'h00;
			if (reg_rd)
			begin
				case (reg_addr)
					`ISM_OFF_BUF:  reg_rdata <= buf_reg;
					`ISM_OFF_CON1: reg_rdata <= {write_collision_flag_reg, ov_reg, en_reg, ckp_reg, mode_reg};
					`ISM_OFF_CON2: reg_rdata <= {general_call_enable_reg, ackst_reg, ack_data_bit_reg, ack_sequence_request_reg,
						receive_request_reg, pen_reg, repeated_start_request_reg, sen_reg};
					`ISM_OFF_ADDR: reg_rdata <= adr_reg;
					`ISM_OFF_STAT: reg_rdata <= {smpcke_reg, da_reg, p_reg, s_reg,
						rw_reg, ua_reg, bf_reg};
					`ISM_OFF_IRQ:  reg_rdata <= {4'h0, serial_irq_flag, 3'h0};
					default:       reg_rdata <= 8'h00;
				endcase
				if (reg_addr == `ISM_OFF_BUF)
					bf_reg <= 1'b0;
			end
			// Bus write
			if (reg_wr)
			begin
				case (reg_addr)
					`ISM_OFF_CON1:
					begin
						{write_collision_flag_reg, ov_reg, en_reg, ckp_reg, mode_reg} <= reg_wdata;
					end
					`ISM_OFF_CON2:
					begin
						general_call_enable_reg  <= reg_wdata[`ISM_C2_GENERAL_CALL_ENABLE];
						ackst_reg <= reg_wdata[`ISM_C2_ACKST];
						ack_data_bit_reg <= reg_wdata[`ISM_C2_ACK_DATA_BIT];
						if (!busy)
						begin
							ack_sequence_request_reg <= reg_wdata[`ISM_C2_ACK_SEQUENCE_REQUEST];
							receive_request_reg  <= reg_wdata[`ISM_C2_RECEIVE_REQUEST];
							pen_reg   <= reg_wdata[`ISM_C2_PEN];
							repeated_start_request_reg  <= reg_wdata[`ISM_C2_REPEATED_START_REQUEST];
						end
						if (!busy | !hwm)
							sen_reg <= reg_wdata[`ISM_C2_SEN];
					end
					`ISM_OFF_ADDR:
					begin
						adr_reg <= reg_wdata;
						ua_reg <= 1'b0;
					end
					`ISM_OFF_STAT: smpcke_reg <= reg_wdata[7:6];
					`ISM_OFF_IRQ:  serial_irq_flag <= reg_wdata[`ISM_IRQ_BIT];
					default: ;
				endcase
			end
			// Buffer write per mode
			if (wr_buf & hwm)
			begin
				if (busy)
					write_collision_flag_reg <= 1'b1;
				else
				begin
					buf_reg <= reg_wdata;
					sr_reg <= reg_wdata;
					rw_reg <= 1'b1;
					mbit_reg <= 4'h0;
					mst_reg <= M_TX;
				end
			end
			else if (wr_buf & slv)
			begin
				if (s_tx & s_act & ckp_reg & (scnt_reg < 4'd8))
					write_collision_flag_reg <= 1'b1;
				else
				begin
					buf_reg <= reg_wdata;
					sr_reg <= reg_wdata;
					bf_reg <= 1'b1;
				end
			end

			// Master: start the queued request when idle
			if (hwm & (mst_reg == M_IDLE))
			begin
				ph_reg <= 2'b00;
				mbit_reg <= 4'h0;
				baud_reg <= adr_reg[6:0];
				if (sen_reg)
					mst_reg <= M_STRT;
				else if (repeated_start_request_reg)
					mst_reg <= M_RSTR;
				else if (pen_reg)
					mst_reg <= M_STOP;
				else if (receive_request_reg)
					mst_reg <= M_RX;
				else if (ack_sequence_request_reg)
					mst_reg <= M_ACK;
			end
			else if (hwm)
			begin
				// Quarter-bit tick every reload+1 clocks, four per bit
				baud_reg <= tick ? adr_reg[6:0] : baud_reg - 7'h01;
				if (tick)
				begin
					ph_reg <= ph_reg + 2'b01;
					case (mst_reg)
						M_STRT:
						begin
							if (ph_reg == 2'd1) m_sda_lo <= 1'b1;
							if (ph_reg == 2'd3)
							begin
								m_scl_lo <= 1'b1;
								sen_reg <= 1'b0;
								mst_reg <= M_IDLE;
							end
						end
						M_RSTR:
						begin
							if (ph_reg == 2'd0) m_sda_lo <= 1'b0;
							if (ph_reg == 2'd1) m_scl_lo <= 1'b0;
							if (ph_reg == 2'd2) m_sda_lo <= 1'b1;
							if (ph_reg == 2'd3)
							begin
								m_scl_lo <= 1'b1;
								repeated_start_request_reg <= 1'b0;
								mst_reg <= M_IDLE;
							end
						end
						M_STOP:
						begin
							if (ph_reg == 2'd0) m_sda_lo <= 1'b1;
							if (ph_reg == 2'd1) m_scl_lo <= 1'b0;
							if (ph_reg == 2'd2) m_sda_lo <= 1'b0;
							if (ph_reg == 2'd3)
							begin
								pen_reg <= 1'b0;
								mst_reg <= M_IDLE;
							end
						end
						M_TX, M_RX, M_ACK:
						begin
							if (ph_reg == 2'd0)
								m_sda_lo <= (mst_reg == M_TX) ? (mbit_reg < 4'd8) & ~sr_reg[7] :
									(mst_reg == M_ACK) & ~ack_data_bit_reg;
							if (ph_reg == 2'd1) m_scl_lo <= 1'b0;
							if (ph_reg == 2'd2)
							begin
								if (mst_reg == M_TX & mbit_reg == 4'd8)
									ackst_reg <= sda_s2;
								if (mst_reg == M_RX)
									sr_reg <= {sr_reg[6:0], sda_s2};
							end
							if (ph_reg == 2'd3)
							begin
								m_scl_lo <= 1'b1;
								mbit_reg <= mbit_reg + 4'h1;
								if (mst_reg == M_TX)
									sr_reg <= {sr_reg[6:0], 1'b0};
								if (mst_reg == M_ACK | (mst_reg == M_TX & mbit_reg == 4'd8))
								begin
									ack_sequence_request_reg <= 1'b0;
									rw_reg <= 1'b0;
									serial_irq_flag <= 1'b1;
									mst_reg <= M_IDLE;
								end
								if (mst_reg == M_RX & mbit_reg == 4'd7)
								begin
									buf_reg <= sr_reg;
									bf_reg <= 1'b1;
									if (bf_reg) ov_reg <= 1'b1;
									receive_request_reg <= 1'b0;
									serial_irq_flag <= 1'b1;
									mst_reg <= M_IDLE;
								end
							end
						end
						default: mst_reg <= M_IDLE;
					endcase
				end
			end
			else
			begin
				// Leaving master mode abandons the sequence and frees the pins
				mst_reg <= M_IDLE;
				m_scl_lo <= 1'b0;
				m_sda_lo <= 1'b0;
			end

			// Slave engine
			if (!slv)
			begin
				{s_act, s_adr, s_tx, s_ack, s_pend} <= 5'h00;
				stage_reg <= 2'd0;
				if (!en_reg) {p_reg, s_reg} <= 2'b00;
			end
			else if (start)
			begin
				{s_reg, p_reg} <= 2'b10;
				{s_act, s_adr, s_tx, s_ack} <= 4'b1100;
				// The start's own clock fall wraps the count to zero before bit one
				scnt_reg <= 4'hf;
				if (ssi) serial_irq_flag <= 1'b1;
			end
			else if (stop)
			begin
				{s_reg, p_reg} <= 2'b01;
				{s_act, s_tx, s_ack} <= 3'b000;
				stage_reg <= 2'd0;
				if (ssi) serial_irq_flag <= 1'b1;
			end
			else if (s_act & rise)
			begin
				if (!s_tx & scnt_reg < 4'd8)
					sr_reg <= {sr_reg[6:0], sda_s2};
				// Master not acknowledging ends a slave transmit
				if (s_tx & scnt_reg == 4'd8 & sda_s2)
					{s_act, s_tx} <= 2'b00;
			end
			else if (s_act & fall)
			begin
				if (scnt_reg == 4'd7)
				begin
					scnt_reg <= 4'd8;
					if (s_tx)
						bf_reg <= 1'b0;
					else if (s_adr & !hit)
						s_act <= 1'b0;
					else
					begin
						s_pend <= 1'b1;
						da_reg <= ~s_adr;
						if (!full)
						begin
							buf_reg <= sr_reg;
							bf_reg <= 1'b1;
							s_ack <= 1'b1;
						end
						else if (!s_adr)
							ov_reg <= 1'b1;
						if (s_adr)
						begin
							rw_reg <= sr_reg[0];
							if (ten & (stage_reg != 2'd2 | !sr_reg[0]))
							begin
								ua_reg <= 1'b1;
								stage_reg <= (stage_reg == 2'd0) ? 2'd1 : 2'd2;
								s_adr <= (stage_reg == 2'd0);
							end
							else
							begin
								s_adr <= 1'b0;
								s_tx <= sr_reg[0];
							end
						end
					end
				end
				else if (scnt_reg == 4'd8)
				begin
					scnt_reg <= 4'h0;
					s_ack <= 1'b0;
					if (s_pend) serial_irq_flag <= 1'b1;
					s_pend <= 1'b0;
					// Transmit always stretches after the address; receive only if enabled
					if (s_tx & (!bf_reg | !da_reg))
						ckp_reg <= 1'b0;
					else if (!s_tx & sen_reg & bf_reg & da_reg)
						ckp_reg <= 1'b0;
				end
				else
				begin
					scnt_reg <= scnt_reg + 4'h1;
					if (s_tx) sr_reg <= {sr_reg[6:0], 1'b0};
				end
			end
		end
	end
endmodule // ism_core

//--- core/ism_regs.vh
`ifndef ISM_REGS_VH
`define ISM_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ISM_OFF_IRQ   8'h0c
`define ISM_OFF_BUF   8'h13
`define ISM_OFF_CON1  8'h14
`define ISM_OFF_CON2  8'h91
`define ISM_OFF_ADDR  8'h93
`define ISM_OFF_STAT  8'h94
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ISM_IRQ_BIT   3
`define ISM_C1_WRITE_COLLISION_FLAG   7
`define ISM_C1_OV     6
`define ISM_C1_EN     5
`define ISM_C1_CKP    4
`define ISM_C2_GENERAL_CALL_ENABLE   7
`define ISM_C2_ACKST  6
`define ISM_C2_ACK_DATA_BIT  5
`define ISM_C2_ACK_SEQUENCE_REQUEST  4
`define ISM_C2_RECEIVE_REQUEST   3
`define ISM_C2_PEN    2
`define ISM_C2_REPEATED_START_REQUEST   1
`define ISM_C2_SEN    0
// ----------------------------------------
// Mode codes and reset values
// ----------------------------------------
`define ISM_MODE_S10I 4'hf
`define ISM_MODE_S7I  4'he
`define ISM_MODE_FWM  4'hb
`define ISM_MODE_HWM  4'h8
`define ISM_MODE_S10  4'h7
`define ISM_MODE_S7   4'h6
`define ISM_RST_BYTE  8'h00
`define ISM_TENBIT_HI 5'h1e
`endif

//--- verif/ism_bus_model.sv
`timescale 1ns/1ps
module ism_bus_model
(
	input  wire ref_clk,
	input  wire scl_w,
	input  wire sda_w,
	output reg  m_scl,
	output reg  m_sda
);
	integer n;
	// Both lines released outside frames
	initial
	begin
		m_scl = 1'b1;
		m_sda = 1'b1;
	end
	// Ten cycles a phase keeps every level well past the input sampler
	task half;
		repeat (10) @(posedge ref_clk);
	endtask
	// Release the clock, then obey a slave that stretches it
	task rise;
	begin
		m_scl <= 1'b1;
		n = 0;
		@(posedge ref_clk);
		while (!scl_w && n < 5000)
		begin
			@(posedge ref_clk);
			n = n + 1;
		end
	end
	endtask
	// One bit: data set while clock low, line read at the end of the high phase
	task bit_io(input v, output s);
	begin
		repeat (3) @(posedge ref_clk);
		m_sda <= v;
		half;
		rise;
		half;
		s = sda_w;
		m_scl <= 1'b0;
	end
	endtask
	// Start, also repeated: data falls while clock high
	task start;
	begin
		@(posedge ref_clk);
		m_sda <= 1'b1;
		half;
		rise;
		half;
		m_sda <= 1'b0;
		half;
		m_scl <= 1'b0;
	end
	endtask
	// Stop: data rises while clock high
	task stop;
	begin
		@(posedge ref_clk);
		m_sda <= 1'b0;
		half;
		rise;
		half;
		m_sda <= 1'b1;
		half;
	end
	endtask
	// Byte MSB first; the ninth clock reads the acknowledge
	task xfer(input [7:0] d, output ack);
		integer i;
		reg s;
	begin
		for (i = 7; i >= 0; i = i - 1)
			bit_io(d[i], s);
		bit_io(1'b1, ack);
	end
	endtask
	// Receiver for the block's master: sample on clock rise, then answer
	task take(output [7:0] d, input nak);
		integer i;
	begin
		for (i = 0; i < 8; i = i + 1)
		begin
			@(posedge scl_w);
			d = {d[6:0], sda_w};
		end
		@(negedge scl_w);
		@(posedge ref_clk);
		m_sda <= nak;
		@(negedge scl_w);
		@(posedge ref_clk);
		m_sda <= 1'b1;
	end
	endtask
	// Transmitter for the block's master: next bit after each clock fall
	task give(input [7:0] d);
		integer i;
	begin
		@(posedge ref_clk);
		m_sda <= d[7];
		for (i = 6; i >= 0; i = i - 1)
		begin
			@(negedge scl_w);
			@(posedge ref_clk);
			m_sda <= d[i];
		end
		@(negedge scl_w);
		@(posedge ref_clk);
		m_sda <= 1'b1;
	end
	endtask
endmodule // ism_bus_model

//--- verif/ism_core_bench.sv
`timescale 1ns/1ps
module ism_core_bench;
	reg        ref_clk, rst_n, reg_wr, reg_rd, gpio_out, gpio_oe, ak;
	reg  [7:0] reg_addr, reg_wdata, v, d, b;
	reg  [1:0] port_c_direction;
	reg  [6:0] a7;
	wire [7:0] reg_rdata;
	wire       scl_out, scl_oe, sda_out, sda_oe, serial_irq_flag, m_scl, m_sda;
	wire       scl_w, sda_w;
	integer    errors, num_checks, cyc, i;
	// Open-drain wires, pulled up when released
	assign scl_w = (scl_oe ? scl_out : 1'b1) & m_scl;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & m_sda;
	ism_core i_ism_core (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_c_direction(port_c_direction), .gpio_scl_out(gpio_out),
		.gpio_scl_oe(gpio_oe), .gpio_sda_out(gpio_out), .gpio_sda_oe(gpio_oe),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .serial_irq_flag(serial_irq_flag));
	ism_bus_model i_ism_bus_model (.ref_clk(ref_clk), .scl_w(scl_w), .sda_w(sda_w),
		.m_scl(m_scl), .m_sda(m_sda));
	// ----------------
	// Clock, ceiling and helpers
	// ----------------
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// A hung handshake ends the run as a failure
	always @(posedge ref_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			errors = errors + 1;
			conclude;
		end
	end
	task conclude;
	begin
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
	begin
		num_checks = num_checks + 1;
		if (g !== e)
		begin
			errors = errors + 1;
			$display("BAD %0s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task nap(input integer n);
	begin
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	end
	endtask
	task wr(input [7:0] a, input [7:0] w);
	begin
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	end
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input [7:0] a, output [7:0] r);
	begin
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		r = reg_rdata;
	end
	endtask
	// Poll one register bit, bounded
	task waitb(input [7:0] a, input integer k, input x);
		integer n;
		reg [7:0] t;
	begin
		n = 0;
		rd(a, t);
		while (t[k] !== x && n < 300)
		begin
			rd(a, t);
			n = n + 1;
		end
		chk("poll", {7'h0, x}, {7'h0, t[k]});
	end
	endtask
	// One byte into the slave; acknowledge on the wire and the flag
	task sx(input [7:0] w, input ea, input ei);
	begin
		wr(8'h0c, 8'h00);
		i_ism_bus_model.xfer(w, ak);
		nap(8);
		chk("ack", {7'h0, ea}, {7'h0, ak});
		chk("irq", {7'h0, ei}, {7'h0, serial_irq_flag});
	end
	endtask
	// ----------------
	// Scenarios
	// ----------------
	initial
	begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
		{gpio_out, gpio_oe, port_c_direction} = 4'hf;
		{errors, num_checks, cyc} = 0;
		v = $urandom(20);
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(8'h14, v);
		chk("con1", 8'h00, v);
		rd(8'h91, v);
		chk("con2", 8'h00, v);
		rd(8'h55, v);
		chk("unmapped", 8'h00, v);
		// Every mode code; only the listed ones take the pins
		for (i = 0; i < 16; i = i + 1)
		begin
			v = $urandom;
			wr(8'h14, {4'h3, i[3:0]});
			gpio_oe <= v[0];
			nap(3);
			b = (i inside {6, 7, 8, 11, 14, 15}) ? 8'h00 : {6'h00, 1'b1, v[0]};
			chk("pins", b, {6'h00, scl_out, scl_oe});
		end
		// Seven-bit slave: match, overflow, clean data byte
		v = $urandom;
		d = $urandom;
		a7 = v[6:0] | 7'h01;
		wr(8'h93, {a7, 1'b0});
		wr(8'h14, 8'h36);
		i_ism_bus_model.start;
		sx({a7, 1'b0}, 1'b0, 1'b1);
		sx(d, 1'b1, 1'b1);
		rd(8'h14, v);
		chk("ovf", 8'h01, {7'h0, v[6]});
		rd(8'h13, v);
		chk("buf", {a7, 1'b0}, v);
		wr(8'h14, 8'h36);
		sx(~d, 1'b0, 1'b1);
		rd(8'h13, v);
		chk("buf", ~d, v);
		wr(8'h0c, 8'h00);
		i_ism_bus_model.stop;
		nap(8);
		chk("irq", 8'h00, {7'h0, serial_irq_flag});
		// Wrong address, then general call on and off
		i_ism_bus_model.start;
		sx({~a7, 1'b0}, 1'b1, 1'b0);
		wr(8'h91, 8'h80);
		i_ism_bus_model.start;
		sx(8'h00, 1'b0, 1'b1);
		rd(8'h13, v);
		wr(8'h91, 8'h00);
		i_ism_bus_model.start;
		sx(8'h00, 1'b1, 1'b0);
		i_ism_bus_model.stop;
		// Start flagged in the interrupt mode
		wr(8'h14, 8'h3e);
		wr(8'h0c, 8'h00);
		i_ism_bus_model.start;
		nap(8);
		chk("irq", 8'h01, {7'h0, serial_irq_flag});
		i_ism_bus_model.stop;
		// Ten-bit slave: each address byte holds the clock until updated
		v = $urandom;
		wr(8'h93, {5'h1e, v[1:0], 1'b0});
		wr(8'h14, 8'h37);
		i_ism_bus_model.start;
		sx({5'h1e, v[1:0], 1'b0}, 1'b0, 1'b1);
		rd(8'h94, b);
		chk("ua", 8'h01, {7'h0, b[1]});
		chk("hold", 8'h01, {7'h0, scl_oe});
		wr(8'h93, d);
		rd(8'h13, b);
		sx(d, 1'b0, 1'b1);
		wr(8'h93, {5'h1e, v[1:0], 1'b0});
		rd(8'h13, b);
		nap(4);
		chk("hold", 8'h00, {7'h0, scl_oe});
		// Stretch enable: a data byte left in the buffer clears the release bit
		wr(8'h91, 8'h01);
		sx(b, 1'b0, 1'b1);
		rd(8'h14, v);
		chk("stretch", 8'h02, {6'h00, scl_oe, v[4]});
		wr(8'h14, 8'h37);
		nap(4);
		chk("release", 8'h00, {7'h0, scl_oe});
		wr(8'h91, 8'h00);
		i_ism_bus_model.stop;
		// Hardware master: collision while busy, two bytes, stop
		wr(8'h93, 8'h03);
		wr(8'h14, 8'h28);
		wr(8'h91, 8'h01);
		wr(8'h13, 8'h5a);
		rd(8'h14, v);
		chk("write_collision_flag", 8'h01, {7'h0, v[7]});
		waitb(8'h91, 0, 1'b0);
		wr(8'h14, 8'h28);
		for (i = 0; i < 2; i = i + 1)
		begin
			wr(8'h0c, 8'h00);
			fork
				i_ism_bus_model.take(b, i[0]);
				wr(8'h13, d ^ i[7:0]);
			join
			waitb(8'h0c, 3, 1'b1);
			chk("tx", d ^ i[7:0], b);
			rd(8'h91, v);
			chk("ackst", {7'h0, i[0]}, {7'h0, v[6]});
		end
		wr(8'h91, 8'h04);
		waitb(8'h91, 2, 1'b0);
		// Master receive, acknowledge bit, repeated start, stop
		wr(8'h91, 8'h01);
		waitb(8'h91, 0, 1'b0);
		fork
			i_ism_bus_model.give(~d);
			wr(8'h91, 8'h08);
		join
		waitb(8'h91, 3, 1'b0);
		rd(8'h13, v);
		chk("rx", ~d, v);
		fork
			@(posedge scl_w) ak = sda_w;
			wr(8'h91, {2'b00, v[0], 5'h10});
		join
		chk("ackbit", {7'h0, v[0]}, {7'h0, ak});
		waitb(8'h91, 4, 1'b0);
		wr(8'h91, 8'h02);
		waitb(8'h91, 1, 1'b0);
		wr(8'h91, 8'h04);
		waitb(8'h91, 2, 1'b0);
		conclude;
	end
endmodule // ism_core_bench

//--- verif/ism_core_sva.sv
`timescale 1ns/1ps
module ism_core_sva
(
	input wire       ref_clk,
	input wire       rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire [1:0] port_c_direction,
	input wire       gpio_scl_out,
	input wire       gpio_scl_oe,
	input wire       scl_in,
	input wire       scl_out,
	input wire       scl_oe,
	input wire       sda_out,
	input wire       sda_oe,
	input wire       serial_irq_flag
);
	reg  [7:0] con1_reg;
	wire       own, slv, fw, hw, irq_wr;
	// ----------------
	// Control one as software wrote it
	// ----------------
	// Enable and mode only; hardware also sets the flag bits
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			con1_reg <= 8'h00;
		else if (reg_wr && reg_addr == 8'h14)
			con1_reg <= reg_wdata;
	end
	// Pins go to the port only for a listed mode with both directions input
	assign own = con1_reg[5] && (&port_c_direction)
		&& (con1_reg[3:0] inside {4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf});
	assign slv = own && con1_reg[2] && con1_reg[1];
	assign fw = own && con1_reg[3:0] == 4'hb;
	assign hw = own && con1_reg[3:0] == 4'h8;
	assign irq_wr = reg_wr && reg_addr == 8'h0c;
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence rd_ctl;
		reg_rd && reg_addr == 8'h14;
	endsequence
	sequence ack_held;
		sda_oe [*8];
	endsequence
	chk_pins_gpio: assert property (
		$past(rst_n) && !$past(own) |-> scl_out == $past(gpio_scl_out)
		&& scl_oe == $past(gpio_scl_oe)) else $error("pins not back on general io");
	chk_pins_owned: assert property ($past(own) |-> !scl_out && !sda_out)
		else $error("owned pin not open drain");
	chk_read_ctl: assert property (
		rd_ctl |=> (reg_rdata & 8'h2f) == ($past(con1_reg) & 8'h2f))
		else $error("control one reads back wrong");
	chk_irq_sticky: assert property (
		$fell(serial_irq_flag) |-> $past(irq_wr) || $past(irq_wr, 2))
		else $error("interrupt flag dropped without software");
	chk_slave_sda: assert property (
		slv && $past(slv) && $past(slv, 2) && $changed(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("slave moved data while clock high");
	chk_ack_hold: assert property (slv && $past(slv) && $rose(sda_oe) |-> ack_held)
		else $error("slave acknowledge too short");
	chk_fw_idle: assert property (fw && $past(fw) && $past(fw, 2) |-> !scl_oe && !sda_oe)
		else $error("firmware master drove a pin");
	chk_master_start: assert property (
		hw && $past(hw) && $rose(sda_oe) && !scl_oe |-> scl_in)
		else $error("data pulled low with clock low and released");
endmodule // ism_core_sva
bind ism_core ism_core_sva i_ism_core_sva (.ref_clk(ref_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .port_c_direction(port_c_direction),
	.gpio_scl_out(gpio_scl_out), .gpio_scl_oe(gpio_scl_oe), .scl_in(scl_in),
	.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
	.serial_irq_flag(serial_irq_flag));
